// ==== hdl/rpt_rom_ram_port_interval_timer.sv ====
// module: top of the rom, ram, two port and interval timer peripheral
`default_nettype none

module rpt_rom_ram_port_interval_timer
#(
   parameter logic [3:0] RAM_PAGE   = rpt_pkg::RAM_PAGE_DEF, // ram page
   parameter logic [3:0] IO_PAGE    = rpt_pkg::IO_PAGE_DEF,  // io page
   parameter logic       CS1_USED   = 1'b0, // port b bit 5 is a select
   parameter logic       CS2_USED   = 1'b0, // port b bit 6 is a select
   parameter logic       CS1_ACTIVE = 1'b1, // level that selects
   parameter logic       CS2_ACTIVE = 1'b1  // level that selects
)
(
   input  wire logic                       clk_i,              // clock
   input  wire logic                       reset_n_i,          // reset
   input  wire logic [rpt_pkg::ADDR_W-1:0] addr_i,             // address
   input  wire logic                       rom_select_input_i, // rom sel
   input  wire logic                       chip_select_one_i,  // select 1
   input  wire logic                       chip_select_two_i,  // select 2
   input  wire logic                       rw_i,               // 1 read
   input  wire logic [7:0]                 data_i,             // bus in
   output logic      [7:0]                 data_o,             // bus out
   output logic                            data_oe_o,          // bus drive
   input  wire logic [7:0]                 port_a_pins_i,      // pin level
   output logic      [7:0]                 port_a_pins_o,      // pin drive
   output logic      [7:0]                 port_a_pins_oe_o,   // pin enable
   input  wire logic [7:0]                 port_b_pins_i,      // pin level
   output logic      [7:0]                 port_b_pins_o,      // pin drive
   output logic      [7:0]                 port_b_pins_oe_o    // pin enable
);
   import rpt_pkg::*;

   // pins given over to chip selects never drive
   localparam logic [7:0] CS_MASK =
      {1'b0, CS2_USED, CS1_USED, 5'b0_0000};

   ////////////////////////////////////////////////////////////////////////
   // elaboration check: ram and io pages must not overlap
   generate
      if (RAM_PAGE == IO_PAGE)
      begin : g_bad_pages
         $error("ram page and io page must differ");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // declarations
   logic [7:0] port_a_direction;   // port a direction register
   logic [7:0] port_b_direction;   // port b direction register
   logic [7:0] port_a_data;        // port a output register
   logic [7:0] port_b_data;        // port b output register
   logic [7:0] ram [RAM_DEPTH];    // static ram
   logic [7:0] pa_meta;            // port a first sync stage
   logic [7:0] pa_sync;            // port a pin levels
   logic [7:0] pb_meta;            // port b first sync stage
   logic [7:0] pb_sync;            // port b pin levels
   logic       cs_ok;              // optional selects agree
   logic       sel_rom;            // rom addressed
   logic       sel_ram;            // ram addressed
   logic       sel_io;             // io or timer addressed
   logic       sel_any;            // something of ours addressed
   logic       io_wr;              // write to a port register
   logic       tmr_acc;            // timer read or write
   logic       tmr_wr;             // timer write
   logic       tmr_rd;             // timer count read
   logic       pa_rd;              // port a data read
   logic [7:0] tmr_count;          // timer count
   logic       tmr_flag;           // timer interrupt flag
   logic       tmr_irq_en;         // flag routed to the pin
   logic       irq_drive;          // pin pulled low by the timer
   logic [7:0] next_rdata;         // read data of this cycle
   logic [7:0] next_pb_o;          // next port b drive
   logic [7:0] next_pb_oe;         // next port b enable

   // stand-in for the mask pattern, one byte per address
   function automatic logic [7:0] rom_byte(input logic [ADDR_W-1:0] a);
      return a[7:0] ^ {a[9:8], a[9:8], a[9:8], a[9:8]};
   endfunction

   // read back: pin level on inputs, output register on outputs
   function automatic logic [7:0] read_port(
      input logic [7:0] pins,
      input logic [7:0] data,
      input logic [7:0] dir);
      return (pins & ~dir) | (data & dir);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // address decode
   // optional selects qualify every access when built
   assign cs_ok   = (!CS1_USED || chip_select_one_i == CS1_ACTIVE) &&
                    (!CS2_USED || chip_select_two_i == CS2_ACTIVE);
   assign sel_rom = cs_ok & rom_select_input_i;
   assign sel_ram = cs_ok & ~rom_select_input_i &
                    (addr_i[9:6] == RAM_PAGE);
   assign sel_io  = cs_ok & ~rom_select_input_i &
                    (addr_i[9:6] == IO_PAGE);
   assign sel_any = sel_rom | sel_ram | sel_io;
   assign io_wr   = sel_io & ~rw_i & ~addr_i[BIT_TMR_SEL];
   assign tmr_acc = sel_io & addr_i[BIT_TMR_SEL];
   assign tmr_wr  = tmr_acc & ~rw_i;
   assign tmr_rd  = tmr_acc & rw_i & ~addr_i[BIT_FLAG_RD];
   assign pa_rd   = sel_io & rw_i & ~addr_i[BIT_TMR_SEL] &
                    (addr_i[1:0] == OFS_PA_DATA);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers, two flops before any logic reads the pins
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pa_meta <= 8'hFF;
         pa_sync <= 8'hFF;
         pb_meta <= 8'hFF;
         pb_sync <= 8'hFF;
      end
      else
      begin
         pa_meta <= port_a_pins_i;
         pa_sync <= pa_meta;
         pb_meta <= port_b_pins_i;
         pb_sync <= pb_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // port registers: written at the end of a selected write cycle
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         port_a_direction <= PORT_RST;
         port_b_direction <= PORT_RST;
         port_a_data      <= PORT_RST;
         port_b_data      <= PORT_RST;
      end
      else if (io_wr)
      begin
         unique case (addr_i[1:0])
            OFS_PA_DATA: port_a_data      <= data_i;
            OFS_PA_DIR:  port_a_direction <= data_i;
            OFS_PB_DATA: port_b_data      <= data_i;
            OFS_PB_DIR:  port_b_direction <= data_i;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ram: byte picked by the low six address bits
   always_ff @(posedge clk_i)
   begin
      if (sel_ram & ~rw_i)
      begin
         ram[addr_i[RAM_AW-1:0]] <= data_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interval timer
   rpt_interval_timer u_timer
   (
      .clk_i      (clk_i),
      .reset_n_i  (reset_n_i),
      .wr_i       (tmr_wr),
      .rd_count_i (tmr_rd),
      .access_i   (tmr_acc),
      .route_i    (addr_i[BIT_IRQ_ROUTE]),
      .div_sel_i  (addr_i[1:0]),
      .wdata_i    (data_i),
      .count_o    (tmr_count),
      .flag_o     (tmr_flag),
      .irq_en_o   (tmr_irq_en)
   );

   // routed flag pulls port b bit 7 low
   assign irq_drive = tmr_flag & tmr_irq_en;

   ////////////////////////////////////////////////////////////////////////
   // read data selection
   always_comb
   begin
      next_rdata = 8'h00;
      if (sel_rom)
      begin
         next_rdata = rom_byte(addr_i);
      end
      else if (sel_ram)
      begin
         next_rdata = ram[addr_i[RAM_AW-1:0]];
      end
      else if (sel_io & addr_i[BIT_TMR_SEL])
      begin
         // flag sits in bit 7 of the flag read
         next_rdata = addr_i[BIT_FLAG_RD] ? {tmr_flag, 7'h00}
                                          : tmr_count;
      end
      else if (sel_io)
      begin
         unique case (addr_i[1:0])
            OFS_PA_DATA: next_rdata =
               read_port(pa_sync, port_a_data, port_a_direction);
            OFS_PA_DIR:  next_rdata = port_a_direction;
            OFS_PB_DATA: next_rdata =
               read_port(pb_sync, port_b_data, port_b_direction);
            OFS_PB_DIR:  next_rdata = port_b_direction;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data bus: driven for one cycle after a selected read
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         data_o    <= 8'h00;
         data_oe_o <= 1'b0;
      end
      else
      begin
         data_o    <= next_rdata;
         data_oe_o <= sel_any & rw_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // port b drive: direction, select pins and the interrupt pin
   always_comb
   begin
      next_pb_oe = port_b_direction & ~CS_MASK;
      next_pb_o  = port_b_data | ~port_b_direction;
      if (irq_drive)
      begin
         next_pb_oe[IRQ_PIN] = 1'b1;
         next_pb_o[IRQ_PIN]  = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drivers: port a inputs float high and outputs show the output register; port b takes the drive worked out above
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         port_a_pins_o    <= 8'hFF;
         port_a_pins_oe_o <= 8'h00;
         port_b_pins_o    <= 8'hFF;
         port_b_pins_oe_o <= 8'h00;
      end
      else
      begin
         port_a_pins_o    <= port_a_data | ~port_a_direction;
         port_a_pins_oe_o <= port_a_direction;
         port_b_pins_o    <= next_pb_o;
         port_b_pins_oe_o <= next_pb_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   AST_DIR_TO_ENABLE: assert property (
      1'b1 |=> port_a_pins_oe_o == $past(port_a_direction))
      else $error("port a enable does not follow direction");

   AST_INPUTS_HIGH: assert property (
      (port_a_pins_o | port_a_pins_oe_o) == 8'hFF)
      else $error("undriven port a pin not high");

   AST_WRITE_LATCH: assert property (
      io_wr && addr_i[1:0] == OFS_PA_DATA
      |=> port_a_data == $past(data_i))
      else $error("port a write not latched");

   AST_READ_OUTPUTS: assert property (
      pa_rd && port_a_direction == 8'hFF |=> data_o == $past(port_a_data))
      else $error("output bits read back wrong");

   AST_READ_KEEPS: assert property (
      pa_rd |=> $stable(port_a_data))
      else $error("port read changed the output register");

   AST_ROM_READ: assert property (
      sel_rom && rw_i |=> data_oe_o && data_o == rom_byte($past(addr_i)))
      else $error("rom read returned wrong byte");

   AST_IRQ_PIN_LOW: assert property (
      irq_drive |=> port_b_pins_oe_o[IRQ_PIN] && !port_b_pins_o[IRQ_PIN])
      else $error("routed interrupt did not pull pin low");

   AST_BUS_QUIET: assert property (
      !(sel_any && rw_i) |=> !data_oe_o)
      else $error("data bus driven outside a read");

   COV_IRQ_PIN: cover property (irq_drive);
   COV_RAM_WR_RD: cover property (sel_ram && !rw_i ##1 sel_ram && rw_i);
   COV_PORT_READ: cover property (pa_rd);

endmodule

`default_nettype wire

// ==== hdl/rpt_pkg.sv ====
// package: shared constants of the rom, ram, port and interval timer block
`default_nettype none

package rpt_pkg;

   // address and storage sizes
   localparam int unsigned ADDR_W    = 10;  // address pins
   localparam int unsigned RAM_AW    = 6;   // byte select bits of the ram
   localparam int unsigned RAM_DEPTH = 64;  // ram bytes
   localparam int unsigned ROM_DEPTH = 1024; // rom bytes

   // io register select, address bits 1..0 while bit 2 is low
   localparam logic [1:0] OFS_PA_DATA = 2'h0; // port a output data
   localparam logic [1:0] OFS_PA_DIR  = 2'h1; // port a direction
   localparam logic [1:0] OFS_PB_DATA = 2'h2; // port b output data
   localparam logic [1:0] OFS_PB_DIR  = 2'h3; // port b direction

   // address bit positions inside the io / timer space
   localparam int unsigned BIT_TMR_SEL   = 2; // high selects the timer
   localparam int unsigned BIT_IRQ_ROUTE = 3; // irq route address bit
   localparam int unsigned BIT_FLAG_RD   = 0; // high reads the flag

   // port b pins with a second use
   localparam int unsigned IRQ_PIN = 7; // timer interrupt, low active
   localparam int unsigned CS1_PIN = 5; // optional chip select one
   localparam int unsigned CS2_PIN = 6; // optional chip select two

   // reset values
   localparam logic [7:0] PORT_RST  = 8'h00; // all pins inputs
   localparam logic [7:0] COUNT_RST = 8'h00; // interval count

   // prescaler select codes, address bits 1..0 on a timer write
   localparam logic [1:0] DIV_1    = 2'h0;
   localparam logic [1:0] DIV_8    = 2'h1;
   localparam logic [1:0] DIV_64   = 2'h2;
   localparam logic [1:0] DIV_1024 = 2'h3;

   // last prescaler state of each period (period minus one clock)
   localparam logic [9:0] PRESC_LAST_1    = 10'h000;
   localparam logic [9:0] PRESC_LAST_8    = 10'h007;
   localparam logic [9:0] PRESC_LAST_64   = 10'h03F;
   localparam logic [9:0] PRESC_LAST_1024 = 10'h3FF;

   // default pages on address bits 9..6 for ram and io / timer
   localparam logic [3:0] RAM_PAGE_DEF = 4'h0;
   localparam logic [3:0] IO_PAGE_DEF  = 4'h8;

endpackage

`default_nettype wire

// ==== hdl/rpt_interval_timer.sv ====
// module: eight bit interval timer with prescaler and interrupt flag
`default_nettype none

module rpt_interval_timer
(
   input  wire logic       clk_i,       // system clock
   input  wire logic       reset_n_i,   // asynchronous reset, low
   input  wire logic       wr_i,        // timer write, one cycle
   input  wire logic       rd_count_i,  // timer count read, one cycle
   input  wire logic       access_i,    // any timer read or write
   input  wire logic       route_i,     // irq route address bit
   input  wire logic [1:0] div_sel_i,   // prescaler select
   input  wire logic [7:0] wdata_i,     // interval count to load
   output logic      [7:0] count_o,     // current count
   output logic            flag_o,      // interrupt flag
   output logic            irq_en_o     // flag routed to the pin
);
   import rpt_pkg::*;

   logic [9:0] presc;       // prescaler state
   logic [9:0] presc_last;  // last state of the chosen period
   logic       period_end;  // prescaler ends a period
   logic       tick;        // count step this cycle
   logic       set_evt;     // zero count runs out

   // last prescaler state for a select code
   function automatic logic [9:0] last_of(input logic [1:0] sel);
      logic [9:0] r;
      r = PRESC_LAST_1;
      unique case (sel)
         DIV_1:    r = PRESC_LAST_1;
         DIV_8:    r = PRESC_LAST_8;
         DIV_64:   r = PRESC_LAST_64;
         DIV_1024: r = PRESC_LAST_1024;
      endcase
      return r;
   endfunction

   assign period_end = (presc == presc_last);
   // after the flag the count steps every clock
   assign tick = flag_o | period_end;
   // a write owns the counter, so no run-out in that cycle
   assign set_evt = tick & ~flag_o & (count_o == 8'h00) & ~wr_i;

   ////////////////////////////////////////////////////////////////////////
   // prescaler: restarts on each write, period chosen by the write
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         presc      <= 10'h000;
         presc_last <= PRESC_LAST_1;
      end
      else if (wr_i)
      begin
         presc      <= 10'h000;
         presc_last <= last_of(div_sel_i);
      end
      else if (period_end)
      begin
         presc <= 10'h000;
      end
      else
      begin
         presc <= presc + 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counter: load on write, step down on each tick, 0 wraps to ff
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         count_o <= COUNT_RST;
      end
      else if (wr_i)
      begin
         count_o <= wdata_i;
      end
      else if (tick)
      begin
         count_o <= count_o - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flag: set wins over a clear by a count read in the same cycle; a write blocks the set
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         flag_o <= 1'b0;
      end
      else if (set_evt)
      begin
         flag_o <= 1'b1;
      end
      else if (wr_i | rd_count_i)
      begin
         flag_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt routing follows the route bit of every timer access
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         irq_en_o <= 1'b0;
      end
      else if (access_i)
      begin
         irq_en_o <= route_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   AST_WRAP_SETS_FLAG: assert property (
      set_evt |=> flag_o && count_o == 8'hFF)
      else $error("run-out did not set flag and wrap count");

   AST_FAST_AFTER_FLAG: assert property (
      flag_o && !wr_i |=> count_o == $past(count_o) - 8'h01)
      else $error("count did not step every clock after flag");

   AST_ACCESS_CLEARS: assert property (
      flag_o && (wr_i || rd_count_i) |=> !flag_o)
      else $error("timer access did not clear the flag");

   AST_SAME_CYCLE_READ: assert property (
      set_evt && rd_count_i |=> flag_o)
      else $error("read in set cycle cleared the flag");

   AST_ROUTE_FOLLOWS: assert property (
      access_i |=> irq_en_o == $past(route_i))
      else $error("interrupt routing did not follow the route bit");

   AST_DIV8_FULL_PERIOD: assert property (
      wr_i && div_sel_i == DIV_8 ##1 (!wr_i) [*8]
      |=> count_o == $past(wdata_i, 9) - 8'h01)
      else $error("first divide by 8 interval not eight clocks");

   COV_FLAG_SET: cover property (set_evt);

endmodule

`default_nettype wire

// ==== verif/rpt_pin_model.sv ====
// model: peripheral device on one port, with the pin pull-up
`default_nettype none

module rpt_pin_model
(
   input  wire logic [7:0] drv_i,    // design pin drive
   input  wire logic [7:0] drv_oe_i, // design drive enable
   input  wire logic [7:0] ext_i,    // peripheral drive
   input  wire logic [7:0] ext_oe_i, // peripheral enable
   output logic      [7:0] pin_o     // resolved pin level
);
   timeunit 1ns;
   timeprecision 1ps;
   // design drive wins; bits nobody drives rest high
   always_comb
   begin
      pin_o = (drv_i & drv_oe_i) | (ext_i & ext_oe_i & ~drv_oe_i)
            | (~drv_oe_i & ~ext_oe_i);
   end
endmodule

`default_nettype wire

// ==== verif/test_rpt_rom_ram_port_interval_timer.sv ====
// testbench: bus, port, memory and timer scenarios
`default_nettype none

module test_rpt_rom_ram_port_interval_timer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] IO = 10'h200; // io page base
   logic       clk_i, reset_n_i, rom_sel, rw_i, data_oe_o;
   logic [9:0] addr_i;
   logic [7:0] data_i, data_o, pa_o, pa_oe, pb_o, pb_oe, pa, pb, ext_a, rd;
   int         n_mismatch, check_count, k;
   int         dv [4] = '{1, 8, 64, 1024};

   rpt_rom_ram_port_interval_timer i_dut
   (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
      .rom_select_input_i(rom_sel), .chip_select_one_i(1'b1),
      .chip_select_two_i(1'b1), .rw_i(rw_i), .data_i(data_i),
      .data_o(data_o), .data_oe_o(data_oe_o), .port_a_pins_i(pa),
      .port_a_pins_o(pa_o), .port_a_pins_oe_o(pa_oe),
      .port_b_pins_i(pb), .port_b_pins_o(pb_o), .port_b_pins_oe_o(pb_oe)
   );
   // port a has a peripheral driving, port b only the pull-up
   rpt_pin_model i_pa (.drv_i(pa_o), .drv_oe_i(pa_oe), .ext_i(ext_a),
      .ext_oe_i(8'hFF), .pin_o(pa));
   rpt_pin_model i_pb (.drv_i(pb_o), .drv_oe_i(pb_oe), .ext_i(8'h00),
      .ext_oe_i(8'h00), .pin_o(pb));

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // compare one value and count it
   task automatic chk(input string n, input logic [7:0] e, s);
      check_count++;
      if (s !== e)
      begin
         $display("FAIL %s expected %h seen %h", n, e, s);
         n_mismatch++;
      end
   endtask

   // one bus cycle, then idle on an unmapped page; rd holds the answer
   task automatic acc(input logic [9:0] a, input logic r,
                      input logic [7:0] d, input logic s = 1'b0);
      @(posedge clk_i);
      addr_i  <= a;
      rw_i    <= r;
      data_i  <= d;
      rom_sel <= s;
      @(posedge clk_i);
      addr_i  <= 10'h3C0;
      rw_i    <= 1'b1;
      rom_sel <= 1'b0;
      #1 rd = data_oe_o ? data_o : 8'hXX;
   endtask

   task automatic conclude;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic t_reset;
      chk("pa_oe", 8'h00, pa_oe);
      chk("pb_pin", 8'hFF, pb);
      acc(IO | 10'h1, 1'b1, 8'h00);
      chk("dir_a", 8'h00, rd);
   endtask

   task automatic t_port;
      acc(IO | 10'h1, 1'b0, 8'h0F);
      acc(IO, 1'b0, 8'h5A);
      acc(IO | 10'h3, 1'b0, 8'h01); // bit 7 stays input
      acc(IO | 10'h2, 1'b0, 8'h00);
      repeat (2) @(posedge clk_i);
      chk("pa_oe", 8'h0F, pa_oe);
      chk("pa_pin", 8'h3A, pa);
      repeat (2)
      begin
         acc(IO, 1'b1, 8'h00);
         chk("pa_rd", 8'h3A, rd);
      end
      acc(IO | 10'h1, 1'b0, 8'hFF);
      acc(IO, 1'b1, 8'h00);
      chk("pa_reg", 8'h5A, rd);
      acc(IO | 10'h2, 1'b1, 8'h00);
      chk("pb_rd", 8'hFE, rd);
   endtask

   task automatic t_mem;
      acc(10'h03F, 1'b0, 8'hC3);
      acc(10'h000, 1'b0, 8'h3C);
      acc(10'h03F, 1'b1, 8'h00);
      chk("ram_top", 8'hC3, rd);
      acc(10'h000, 1'b1, 8'h00);
      chk("ram_bot", 8'h3C, rd);
      acc(10'h2A5, 1'b1, 8'h00, 1'b1);
      chk("rom", 8'h0F, rd);
      acc(10'h3C0, 1'b1, 8'h00);
      chk("bus_off", 8'h00, {7'h0, data_oe_o});
   endtask

   // count of one for each prescaler, irq routed to the pin
   task automatic t_pre;
      for (int i = 0; i < 4; i++)
      begin
         acc(IO | 10'hC | 10'(i), 1'b0, 8'h01);
         for (k = 0; k < 3000 && pb[7] !== 1'b0; k++)
            @(posedge clk_i) #1;
         if (k >= 3000)
         begin
            chk("irq_hang", 8'h01, 8'h00);
            return;
         end
         chk("irq_time", 8'h01,
             8'((k == 2*dv[i]) || (k == 2*dv[i]+1)));
         acc(IO | 10'hD, 1'b1, 8'h00);
         chk("flag_set", 8'h80, rd);
         acc(IO | 10'h4, 1'b1, 8'h00);
         chk("since", 8'h0F, 8'(rd[7:4]));
         acc(IO | 10'h5, 1'b1, 8'h00);
         chk("flag_clr", 8'h00, rd);
         @(posedge clk_i) #1;
         chk("pin_free", 8'h01, 8'(pb[7]));
      end
   endtask

   task automatic t_early;
      // divide by 1, route off: the count read meets the run-out
      acc(IO | 10'h4, 1'b0, 8'h01);
      acc(IO | 10'h4, 1'b1, 8'h00);
      chk("cnt_zero", 8'h00, rd);
      acc(IO | 10'h5, 1'b1, 8'h00);
      chk("flag_kept", 8'h80, rd);
      chk("pin_off", 8'h01, 8'(pb[7]));
      // a flag read with the route bit set hands the flag to the pin
      acc(IO | 10'hD, 1'b1, 8'h00);
      @(posedge clk_i) #1;
      chk("pin_on", 8'h00, 8'(pb[7]));
      acc(IO | 10'h6, 1'b0, 8'h05);
      acc(IO | 10'h4, 1'b1, 8'h00);
      chk("left5", 8'h05, rd);
      repeat (64) @(posedge clk_i);
      acc(IO | 10'h4, 1'b1, 8'h00);
      chk("left4", 8'h04, rd);
   endtask

   initial
   begin
      reset_n_i   = 1'b0;
      rom_sel     = 1'b0;
      rw_i        = 1'b1;
      addr_i      = 10'h3C0;
      data_i      = 8'h00;
      ext_a       = 8'h3C;
      n_mismatch  = 0;
      check_count = 0;
      repeat (10) @(posedge clk_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_port();
      t_mem();
      t_pre();
      t_early();
      conclude();
   end
endmodule

`default_nettype wire
